// ===== tfid_pkg.sv
// Shared constants and types for the pin-float and identification logic
package tfid_pkg;

  // Number of ordinary device pins gated by the all-float test mode
  localparam int PIN_COUNT = 8;

  // Identification register layout
  localparam int ID_WIDTH = 32;
  localparam int VERSION_WIDTH = 4;
  localparam int PART_WIDTH = 16;
  localparam int MFR_WIDTH = 11;
  localparam int VERSION_MSB = 31;
  localparam int VERSION_LSB = 28;
  localparam int PART_MSB = 27;
  localparam int PART_LSB = 12;
  localparam int MFR_MSB = 11;
  localparam int MFR_LSB = 1;
  localparam int MARK_BIT = 0;
  localparam logic ID_MARK = 1'b1;

  // Instruction register
  localparam int IR_WIDTH = 4;
  localparam logic [IR_WIDTH-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;

  // Fixed levels of the supply indication pins
  localparam logic SUPPLY_SPLIT_LEVEL = 1'b0;
  localparam logic CORE_VOLT_LEVEL = 1'b0;

  // Identification word fields
  typedef struct packed {
    logic [VERSION_WIDTH-1:0] version;
    logic [PART_WIDTH-1:0] part;
    logic [MFR_WIDTH-1:0] mfr;
    logic mark;
  } tfid_id_t;

  // Scan controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tfid_tap_t;

endpackage

// ===== tfid_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module tfid_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Shift chain; only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change only once two settled stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end

endmodule

// ===== tfid_top.sv
// Supply indication pins, all-float test mode and scan identification register
// How it works
// RQ1 - Supply split detect pin is always driven low, never floated.
// RQ2 - Core voltage select pin is always driven low, never floated.
// RQ3 - Board logic samples core voltage select after seeing split detect low.
// RQ4 - Board logic should weakly pull up core voltage select.
// RQ5 - Core voltage select is low right after reset is seen asserted.
// RQ6 - Float mode releases every pin except the two supply pins and TDO.
// RQ7 - TDO stays driven at all times, float mode included.
// RQ8 - Sampling reset asserted ends float mode.
// RQ9 - A 32-bit identification register sits in the scan path for IDCODE.
// RQ10 - Bits 31 to 28 hold the silicon version.
// RQ11 - Bits 27 to 12 hold the part number.
// RQ12 - Bits 11 to 1 hold the maker identity.
// RQ13 - Bit 0 of the identification word is always one.
// RQ14 - Loaded in Capture-DR, shifted out lowest bit first in Shift-DR.
// RQ15 - A dedicated request input enters float mode; reset clears it.
`timescale 1ns/10ps
module tfid_top #(
  parameter logic [tfid_pkg::VERSION_WIDTH-1:0] VERSION_CODE = 4'h1, // Value arbitrary
  parameter logic [tfid_pkg::PART_WIDTH-1:0] PART_CODE = 16'h1234, // Value arbitrary
  parameter logic [tfid_pkg::MFR_WIDTH-1:0] MFR_CODE = 11'h2a5 // Value arbitrary
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RESET,
  input wire logic FLOAT_REQ,
  input wire logic [tfid_pkg::PIN_COUNT-1:0] PIN_DATA_I,
  input wire logic [tfid_pkg::PIN_COUNT-1:0] PIN_EN_I,
  output logic [tfid_pkg::PIN_COUNT-1:0] PIN_O,
  output logic [tfid_pkg::PIN_COUNT-1:0] PIN_OE,
  output logic FLOAT_ACTIVE,
  output logic SUPPLY_SPLIT_DETECT,
  output logic SUPPLY_SPLIT_DETECT_OE,
  output logic CORE_VOLTAGE_SELECT,
  output logic CORE_VOLTAGE_SELECT_OE,
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE
);

  // Core clock domain signals
  logic reset_s;
  logic float_req_s;
  logic float_mode_reg;
  logic float_mode_next;
  logic cvs_reg;
  logic [tfid_pkg::PIN_COUNT-1:0] pin_o_reg;
  logic [tfid_pkg::PIN_COUNT-1:0] pin_oe_reg;
  logic [tfid_pkg::PIN_COUNT-1:0] pin_oe_next;

  // Scan clock domain signals
  tfid_pkg::tfid_tap_t state_reg;
  tfid_pkg::tfid_tap_t state_next;
  logic [tfid_pkg::IR_WIDTH-1:0] ir_shift_reg;
  logic [tfid_pkg::IR_WIDTH-1:0] ir_reg;
  logic [tfid_pkg::ID_WIDTH-1:0] id_shift_reg;
  logic bypass_reg;
  logic tdo_reg;
  logic tdo_next;
  tfid_pkg::tfid_id_t id_word;

  // Reset pin and float request come from outside the core clock
  tfid_sync3 #(
    .RST_VAL(1'b0)
  ) u_sync_reset (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(RESET),
    .sync_out(reset_s)
  );

  tfid_sync3 #(
    .RST_VAL(1'b0)
  ) u_sync_float (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(FLOAT_REQ),
    .sync_out(float_req_s)
  );

  // Reset outranks a pending request so the mode always exits
  always_comb begin
    float_mode_next = float_mode_reg;
    if (reset_s) begin
      float_mode_next = 1'b0; // RQ8
    end else if (float_req_s) begin
      float_mode_next = 1'b1; // RQ15
    end
  end

  // Float mode flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      float_mode_reg <= 1'b0;
    end else begin
      float_mode_reg <= float_mode_next;
    end
  end

  // Per-pin enable gating; the mode takes effect with the flag itself
  genvar gi;
  generate
    for (gi = 0; gi < tfid_pkg::PIN_COUNT; gi++) begin : g_pin
      assign pin_oe_next[gi] = PIN_EN_I[gi] & ~float_mode_next; // RQ6
    end
  endgenerate

  // Registered pin data and enables
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_o_reg <= '0;
      pin_oe_reg <= '0;
    end else begin
      pin_o_reg <= PIN_DATA_I;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // Voltage select held at its fixed level, re-forced on every reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cvs_reg <= tfid_pkg::CORE_VOLT_LEVEL;
    end else if (reset_s) begin
      cvs_reg <= tfid_pkg::CORE_VOLT_LEVEL; // RQ5
    end else begin
      cvs_reg <= tfid_pkg::CORE_VOLT_LEVEL; // RQ2
    end
  end

  // Supply pins never see the float gate, so the supply stays correct
  assign SUPPLY_SPLIT_DETECT = tfid_pkg::SUPPLY_SPLIT_LEVEL; // RQ1
  assign SUPPLY_SPLIT_DETECT_OE = 1'b1; // RQ1
  assign CORE_VOLTAGE_SELECT = cvs_reg; // RQ2
  assign CORE_VOLTAGE_SELECT_OE = 1'b1; // RQ2
  assign PIN_O = pin_o_reg;
  assign PIN_OE = pin_oe_reg;
  assign FLOAT_ACTIVE = float_mode_reg;

  // Identification word assembled from its fields
  assign id_word.version = VERSION_CODE; // RQ10
  assign id_word.part = PART_CODE; // RQ11
  assign id_word.mfr = MFR_CODE; // RQ12
  assign id_word.mark = tfid_pkg::ID_MARK; // RQ13

  // Scan controller next state
  always_comb begin
    case (state_reg)
      tfid_pkg::TEST_LOGIC_RESET: state_next = TMS ? tfid_pkg::TEST_LOGIC_RESET : tfid_pkg::RUN_TEST_IDLE;
      tfid_pkg::RUN_TEST_IDLE: state_next = TMS ? tfid_pkg::SELECT_DR : tfid_pkg::RUN_TEST_IDLE;
      tfid_pkg::SELECT_DR: state_next = TMS ? tfid_pkg::SELECT_IR : tfid_pkg::CAPTURE_DR;
      tfid_pkg::CAPTURE_DR: state_next = TMS ? tfid_pkg::EXIT1_DR : tfid_pkg::SHIFT_DR;
      tfid_pkg::SHIFT_DR: state_next = TMS ? tfid_pkg::EXIT1_DR : tfid_pkg::SHIFT_DR;
      tfid_pkg::EXIT1_DR: state_next = TMS ? tfid_pkg::UPDATE_DR : tfid_pkg::PAUSE_DR;
      tfid_pkg::PAUSE_DR: state_next = TMS ? tfid_pkg::EXIT2_DR : tfid_pkg::PAUSE_DR;
      tfid_pkg::EXIT2_DR: state_next = TMS ? tfid_pkg::UPDATE_DR : tfid_pkg::SHIFT_DR;
      tfid_pkg::UPDATE_DR: state_next = TMS ? tfid_pkg::SELECT_DR : tfid_pkg::RUN_TEST_IDLE;
      tfid_pkg::SELECT_IR: state_next = TMS ? tfid_pkg::TEST_LOGIC_RESET : tfid_pkg::CAPTURE_IR;
      tfid_pkg::CAPTURE_IR: state_next = TMS ? tfid_pkg::EXIT1_IR : tfid_pkg::SHIFT_IR;
      tfid_pkg::SHIFT_IR: state_next = TMS ? tfid_pkg::EXIT1_IR : tfid_pkg::SHIFT_IR;
      tfid_pkg::EXIT1_IR: state_next = TMS ? tfid_pkg::UPDATE_IR : tfid_pkg::PAUSE_IR;
      tfid_pkg::PAUSE_IR: state_next = TMS ? tfid_pkg::EXIT2_IR : tfid_pkg::PAUSE_IR;
      tfid_pkg::EXIT2_IR: state_next = TMS ? tfid_pkg::UPDATE_IR : tfid_pkg::SHIFT_IR;
      tfid_pkg::UPDATE_IR: state_next = TMS ? tfid_pkg::SELECT_DR : tfid_pkg::RUN_TEST_IDLE;
      default: state_next = tfid_pkg::TEST_LOGIC_RESET;
    endcase
  end

  // Scan controller state; runs on the scan clock only
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      state_reg <= tfid_pkg::TEST_LOGIC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction shift path and latched instruction
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      ir_shift_reg <= '0;
      ir_reg <= tfid_pkg::IR_IDCODE;
    end else begin
      case (state_reg)
        tfid_pkg::TEST_LOGIC_RESET: ir_reg <= tfid_pkg::IR_IDCODE;
        tfid_pkg::CAPTURE_IR: ir_shift_reg <= tfid_pkg::IR_CAPTURE;
        tfid_pkg::SHIFT_IR: ir_shift_reg <= {TDI, ir_shift_reg[tfid_pkg::IR_WIDTH-1:1]};
        tfid_pkg::UPDATE_IR: ir_reg <= ir_shift_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Identification data path; other instructions fall to bypass
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      id_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end else if (state_reg == tfid_pkg::CAPTURE_DR) begin
      bypass_reg <= 1'b0;
      if (ir_reg == tfid_pkg::IR_IDCODE) begin
        id_shift_reg <= id_word; // RQ9 RQ14
      end
    end else if (state_reg == tfid_pkg::SHIFT_DR) begin
      bypass_reg <= TDI;
      if (ir_reg == tfid_pkg::IR_IDCODE) begin
        id_shift_reg <= {TDI, id_shift_reg[tfid_pkg::ID_WIDTH-1:1]}; // RQ14
      end
    end
  end

  // Output mux: lowest bit first
  always_comb begin
    tdo_next = tdo_reg;
    if (state_reg == tfid_pkg::SHIFT_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (state_reg == tfid_pkg::SHIFT_DR) begin
      tdo_next = (ir_reg == tfid_pkg::IR_IDCODE) ? id_shift_reg[0] : bypass_reg; // RQ14
    end
  end

  // Falling edge launch gives the far end a half period of setup
  always_ff @(negedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      tdo_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
    end
  end

  // Scan output is never released, float mode or not
  assign TDO = tdo_reg;
  assign TDO_OE = 1'b1; // RQ7

  // Checks on the core clock
  chk_split_low: assert property (@(posedge CLK) disable iff (!RST_N) // RQ1
    SUPPLY_SPLIT_DETECT == 1'b0 && SUPPLY_SPLIT_DETECT_OE && $stable(SUPPLY_SPLIT_DETECT))
    else $error("supply split detect not driven low");

  chk_volt_low: assert property (@(posedge CLK) disable iff (!RST_N) // RQ2
    float_mode_reg |-> CORE_VOLTAGE_SELECT == 1'b0 && CORE_VOLTAGE_SELECT_OE)
    else $error("core voltage select floated or high in float mode");

  chk_volt_reset: assert property (@(posedge CLK) disable iff (!RST_N) // RQ5
    reset_s |=> CORE_VOLTAGE_SELECT == 1'b0 ##1 CORE_VOLTAGE_SELECT == 1'b0)
    else $error("core voltage select not low after reset");

  chk_float_gates: assert property (@(posedge CLK) disable iff (!RST_N) // RQ6
    float_mode_reg |-> PIN_OE == '0)
    else $error("pin driven during float mode");

  chk_float_exit: assert property (@(posedge CLK) disable iff (!RST_N) // RQ8
    reset_s |=> !float_mode_reg && PIN_OE == $past(PIN_EN_I))
    else $error("float mode not left on reset");

  chk_float_entry: assert property (@(posedge CLK) disable iff (!RST_N) // RQ15
    float_req_s && !reset_s |=> float_mode_reg ##0 PIN_OE == '0)
    else $error("float request not honoured");

  // Checks on the scan clock
  chk_tdo_driven: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ7
    TDO_OE)
    else $error("scan output released");

  chk_id_load: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ9
    state_reg == tfid_pkg::CAPTURE_DR && ir_reg == tfid_pkg::IR_IDCODE
    |=> id_shift_reg[tfid_pkg::VERSION_MSB:tfid_pkg::VERSION_LSB] == VERSION_CODE
    && id_shift_reg[tfid_pkg::PART_MSB:tfid_pkg::PART_LSB] == PART_CODE)
    else $error("identification version or part wrong after capture");

  chk_id_fields: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ12
    state_reg == tfid_pkg::CAPTURE_DR && ir_reg == tfid_pkg::IR_IDCODE
    |=> id_shift_reg[tfid_pkg::MFR_MSB:tfid_pkg::MFR_LSB] == MFR_CODE
    && id_shift_reg[tfid_pkg::MARK_BIT] == 1'b1) // RQ13
    else $error("identification maker or mark bit wrong after capture");

  chk_id_shift: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ14
    state_reg == tfid_pkg::SHIFT_DR && ir_reg == tfid_pkg::IR_IDCODE
    |=> id_shift_reg == {$past(TDI), $past(id_shift_reg[tfid_pkg::ID_WIDTH-1:1])})
    else $error("identification register did not shift right");

  // Ordinary pin data is a plain one-cycle copy, float or not
  chk_pin_data: assert property (@(posedge CLK) disable iff (!RST_N) // RQ6
    PIN_O == $past(PIN_DATA_I))
    else $error("pin data not passed through");

  chk_float_holds: assert property (@(posedge CLK) disable iff (!RST_N) // RQ15
    float_mode_reg && !reset_s |=> float_mode_reg)
    else $error("float mode dropped without reset");

  // TDO launched on the fall must show the bit the next rise consumes
  chk_tdo_lsb: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ14
    state_reg == tfid_pkg::SHIFT_DR && ir_reg == tfid_pkg::IR_IDCODE |-> TDO == id_shift_reg[0])
    else $error("scan output not lowest identification bit");

  chk_bypass_shift: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ9
    state_reg == tfid_pkg::SHIFT_DR |=> bypass_reg == $past(TDI))
    else $error("bypass stage did not take scan input");

  chk_id_parked: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ9
    state_reg == tfid_pkg::SHIFT_DR && ir_reg != tfid_pkg::IR_IDCODE |=> $stable(id_shift_reg))
    else $error("identification register shifted outside its instruction");

  chk_ir_update: assert property (@(posedge TCK) disable iff (!TRST_N) // RQ9
    state_reg == tfid_pkg::UPDATE_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not latched on update");

endmodule

// ===== tfid_board_model.sv
// Board logic and scan controller model facing the float and identification block
`timescale 1ns/10ps
module tfid_board_model (
  input wire logic ssd,
  input wire logic ssd_oe,
  input wire logic cvs,
  input wire logic cvs_oe,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  output logic low_core
);
  logic cvs_wire;
  logic tdo_seen;
  // Weak pullup, so a released select line reads high
  assign cvs_wire = cvs_oe ? cvs : 1'b1;
  // Core level is only read once split detect shows low
  assign low_core = (ssd_oe && ssd == 1'b0) ? (cvs_wire == 1'b0) : 1'b0;
  // A released scan output must not look like a valid bit
  assign tdo_seen = tdo_oe ? tdo : ~tdo;
  // Scan clock idles low outside frames
  initial begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    #43 trst_n = 1'b1;
  end
  // One scan cycle: set up after the fall, sample on the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16 tck = 1'b1;
    q = tdo_seen;
    #16 tck = 1'b0;
  endtask
  // Reset controller, enter Shift-DR and collect 32 bits, lowest first
  task automatic read_id(output logic [31:0] id);
    logic q;
    for (int i = 0; i < 5; i++) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, i[0], q);
      id[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // Load an instruction, keep its capture bits, then shift 32 data bits with an alternating input
  task automatic scan_ir_dr(input logic [3:0] ir, output logic [3:0] cap, output logic [31:0] dr);
    logic q;
    for (int i = 0; i < 5; i++) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int j = 0; j < 4; j++) begin
      tick(j == 3, ir[j], q);
      cap[j] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, i[0], q);
      dr[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the pin-float and identification block
`timescale 1ns/10ps
module testbench;
  localparam logic [3:0] VER = 4'h6; // Value arbitrary
  localparam logic [15:0] PART = 16'h0c3a; // Value arbitrary
  localparam logic [10:0] MFR = 11'h155; // Value arbitrary
  logic clk, rst_n, reset, float_req;
  logic [tfid_pkg::PIN_COUNT-1:0] pin_data, pin_en, pin_o, pin_oe;
  logic float_active, ssd, ssd_oe, cvs, cvs_oe;
  logic tck, trst_n, tms, tdi, tdo, tdo_oe, low_core;
  logic [3:0] ir_cap;
  logic [31:0] dr_word;
  int num_errors = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;

  tfid_top #(.VERSION_CODE(VER), .PART_CODE(PART), .MFR_CODE(MFR)) i_dut (
    .CLK(clk), .RST_N(rst_n), .RESET(reset), .FLOAT_REQ(float_req),
    .PIN_DATA_I(pin_data), .PIN_EN_I(pin_en), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .FLOAT_ACTIVE(float_active), .SUPPLY_SPLIT_DETECT(ssd), .SUPPLY_SPLIT_DETECT_OE(ssd_oe),
    .CORE_VOLTAGE_SELECT(cvs), .CORE_VOLTAGE_SELECT_OE(cvs_oe),
    .TCK(tck), .TRST_N(trst_n), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));

  tfid_board_model i_board (
    .ssd(ssd), .ssd_oe(ssd_oe), .cvs(cvs), .cvs_oe(cvs_oe), .tdo(tdo), .tdo_oe(tdo_oe),
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .low_core(low_core));

  // Verdict and end of run
  task automatic results();
    $display("TB: errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait on the float flag; sync chain takes a handful of cycles
  task automatic wait_float(input logic lvl);
    for (int n = 0; n < 40 && float_active !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    if (float_active !== lvl) begin
      num_errors++;
      results();
    end
  endtask

  // Supply pins and scan output are driven in every mode
  task automatic check_fixed();
    check(32'({ssd, ssd_oe}), 32'h1);
    check(32'({cvs, cvs_oe}), 32'h1);
    check(32'(tdo_oe), 32'h1);
    check(32'(low_core), 32'h1);
  endtask

  // Scan out the identification word and compare each field
  task automatic check_id();
    logic [31:0] id;
    i_board.read_id(id);
    check(32'(id[31:28]), 32'(VER));
    check(32'(id[27:12]), 32'(PART));
    check(32'(id[11:1]), 32'(MFR));
    check(32'(id[0]), 32'h1);
    check(id, {VER, PART, MFR, 1'b1});
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reset = 1'b0;
    float_req = 1'b0;
    pin_data = '0;
    pin_en = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    pin_data <= 8'ha5;
    pin_en <= 8'h3c;
    repeat (6) @(posedge clk);
    #1;
    check(32'({pin_o, pin_oe}), 32'ha53c);
    check(32'(float_active), 32'h0);
    check_fixed();
    check_id();
    $display("TB: normal mode test done");
    // Level request enters float; it stands after the request drops
    @(posedge clk);
    float_req <= 1'b1;
    wait_float(1'b1);
    check(32'(pin_oe), 32'h0);
    @(posedge clk);
    float_req <= 1'b0;
    pin_en <= 8'hff;
    repeat (12) @(posedge clk);
    #1;
    check(32'({float_active, pin_oe}), 32'h100);
    check_fixed();
    check_id();
    $display("TB: float mode test done");
    // Reset ends float, and wins over a request held with it
    @(posedge clk);
    reset <= 1'b1;
    float_req <= 1'b1;
    wait_float(1'b0);
    check(32'(cvs), 32'h0);
    repeat (10) @(posedge clk);
    #1;
    check(32'({float_active, pin_oe}), 32'h0ff);
    @(posedge clk);
    float_req <= 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(32'({float_active, pin_oe}), 32'h0ff);
    check_fixed();
    $display("TB: reset exit test done");
    // Loaded instructions; bypass captures zero, then echoes the input one bit late
    i_board.scan_ir_dr(tfid_pkg::IR_IDCODE, ir_cap, dr_word);
    check(32'(ir_cap), 32'(tfid_pkg::IR_CAPTURE));
    check(dr_word, {VER, PART, MFR, 1'b1});
    i_board.scan_ir_dr(tfid_pkg::IR_BYPASS, ir_cap, dr_word);
    check(dr_word, 32'h55555554);
    i_board.scan_ir_dr(4'h5, ir_cap, dr_word);
    check(dr_word, 32'h55555554);
    $display("TB: instruction test done");
    results();
  end
endmodule
